// >>> shared/pgw_pkg.sv
// Constants, register map and state type of the power-good and warning flag block
`default_nettype none
package pgw_pkg;
   // ----------------------------------------------------------------
   // Sizes and timing
   // ----------------------------------------------------------------
   localparam int NUM_RAILS       = 4;
   localparam int CNT_W           = 18;
   localparam int CLK_MHZ         = 250;
   localparam int INVALID_FILT_US = 7;
   localparam int VALID_SHORT_US  = 4;
   localparam int VALID_LONG_US   = 8;
   localparam int ILIM_DEB_US     = 20;
   localparam int THERM_DEB_US    = 20;
   localparam int OVLD_DEB_MS     = 1;
   localparam int INVALID_CYC     = INVALID_FILT_US * CLK_MHZ;
   localparam int VALID_SHORT_CYC = VALID_SHORT_US * CLK_MHZ;
   localparam int VALID_LONG_CYC  = VALID_LONG_US * CLK_MHZ;
   localparam int ILIM_DEB_CYC    = ILIM_DEB_US * CLK_MHZ;
   localparam int THERM_DEB_CYC   = THERM_DEB_US * CLK_MHZ;
   localparam int OVLD_DEB_CYC    = OVLD_DEB_MS * 1000 * CLK_MHZ;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL        = 8'h00;
   localparam logic [7:0] ADDR_SRC_CTRL    = 8'h01;
   localparam logic [7:0] ADDR_OUT_CTRL    = 8'h02;
   localparam logic [7:0] ADDR_FAULT_SRC   = 8'h03;
   localparam logic [7:0] ADDR_TOP_FLAG    = 8'h04;
   localparam logic [7:0] ADDR_REG_FLAG    = 8'h05;
   localparam logic [7:0] ADDR_STATUS      = 8'h06;
   localparam logic [7:0] ADDR_ON_STATUS   = 8'h07;
   localparam logic [7:0] ADDR_MASK        = 8'h08;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_SWRST_BIT   = 0;
   localparam int CTRL_THRESH_BIT  = 1;
   localparam int OC_WINDOW_BIT    = 0;
   localparam int OC_POL_BIT       = 1;
   localparam int OC_OD_BIT        = 2;
   localparam int OC_SETDLY_BIT    = 3;
   localparam int OC_STICKY_BIT    = 4;
   localparam int TOP_RESET_BIT    = 0;
   localparam int TOP_THERM_BIT    = 1;
   localparam int MASK_RESET_BIT   = 0;
   localparam int MASK_THERM_BIT   = 1;
   localparam int MASK_ILIM_LSB    = 2;
   localparam int SC_FLAG_LSB      = 4;
   localparam int ST_THERM_BIT     = 4;
   localparam int ST_PG_BIT        = 5;
   // ----------------------------------------------------------------
   // Monitor source selection
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_NONE     = 2'b00,
      SEL_VOLTAGE  = 2'b01,
      SEL_COMBINED = 2'b10,
      SEL_COMB_ALT = 2'b11
   } pgw_sel_type;
   // ----------------------------------------------------------------
   // Whole state of the block
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2*NUM_RAILS-1:0]            srcCtrl;
      logic [4:0]                        outCtrl;
      logic [NUM_RAILS+1:0]              mask;
      logic                              threshSel;
      logic                              swResetReq;
      logic                              resetFlag;
      logic                              thermFlag;
      logic [NUM_RAILS-1:0]              ilimFlag;
      logic [NUM_RAILS-1:0]              scFlag;
      logic [NUM_RAILS-1:0]              faultBits;
      logic [NUM_RAILS-1:0]              vFilt;
      logic [NUM_RAILS-1:0]              iFilt;
      logic [NUM_RAILS-1:0]              oFilt;
      logic                              tFilt;
      logic [NUM_RAILS-1:0][CNT_W-1:0]   vCnt;
      logic [NUM_RAILS-1:0][CNT_W-1:0]   iCnt;
      logic [NUM_RAILS-1:0][CNT_W-1:0]   oCnt;
      logic [CNT_W-1:0]                  tCnt;
      logic                              pgActive;
      logic                              prevPin;
      logic [7:0]                        rdData;
   } pgw_state_type;
endpackage : pgw_pkg
`default_nettype wire

// >>> rtl/pgw_power_good.sv
// Power-good combiner, fault source record and warning flags
`default_nettype none
module pgw_power_good
   import pgw_pkg::*;
#(
   parameter int ILIM_CYC  = ILIM_DEB_CYC,
   parameter int THERM_CYC = THERM_DEB_CYC,
   parameter int OVLD_CYC  = OVLD_DEB_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   input  wire logic [7:0]           regAddr,
   input  wire logic [7:0]           regWrData,
   input  wire logic                 regWrite,
   input  wire logic                 regRead,
   output logic      [7:0]           regRdData,
   input  wire logic                 externalResetPin,
   input  wire logic                 supplyGlitch,
   input  wire logic [NUM_RAILS-1:0] regEnable,
   input  wire logic [NUM_RAILS-1:0] outAboveUv,
   input  wire logic [NUM_RAILS-1:0] outBelowOv,
   input  wire logic [NUM_RAILS-1:0] rampActive,
   input  wire logic [NUM_RAILS-1:0] shutdownPhase,
   input  wire logic [NUM_RAILS-1:0] forwardCurrentLimit,
   input  wire logic [NUM_RAILS-1:0] outputCollapsed,
   input  wire logic                 thermalSdPending,
   input  wire logic                 supplyOvPending,
   input  wire logic [1:0]           dieAboveWarn,
   output logic                      powerGoodOut,
   output logic                      powerGoodOe,
   output logic                      irqLineNOut,
   output logic                      irqLineNOe,
   output logic [NUM_RAILS-1:0]      regulatorOnStatus,
   output logic [NUM_RAILS-1:0]      regulatorShutdown
);

   // ----------------------------------------------------------------
   // Debounce step: returns filtered value and count
   // ----------------------------------------------------------------
   function automatic logic [CNT_W:0] deb_step(input logic             raw,
                                               input logic             filt,
                                               input logic [CNT_W-1:0] cnt,
                                               input logic [CNT_W-1:0] limit);
      logic [CNT_W-1:0] inc;
      inc = cnt + 1'b1;
      if (raw == filt) begin
         deb_step = {filt, {CNT_W{1'b0}}};
      end else if (inc >= limit) begin
         deb_step = {raw, {CNT_W{1'b0}}};
      end else begin
         deb_step = {filt, inc};
      end
   endfunction : deb_step

   localparam logic [CNT_W-1:0] LIM_INVALID = CNT_W'(INVALID_CYC);
   localparam logic [CNT_W-1:0] LIM_VSHORT  = CNT_W'(VALID_SHORT_CYC);
   localparam logic [CNT_W-1:0] LIM_VLONG   = CNT_W'(VALID_LONG_CYC);
   localparam logic [CNT_W-1:0] LIM_ILIM    = CNT_W'(ILIM_CYC);
   localparam logic [CNT_W-1:0] LIM_THERM   = CNT_W'(THERM_CYC);
   localparam logic [CNT_W-1:0] LIM_OVLD    = CNT_W'(OVLD_CYC);

   pgw_state_type        st_reg;
   pgw_state_type        st_next;
   logic                 resetEvent;
   logic                 readFault;
   logic [NUM_RAILS-1:0] vRaw;
   logic [NUM_RAILS-1:0] railIn;
   logic [NUM_RAILS-1:0] disPending;
   logic [7:0]           clrTop;
   logic [7:0]           clrReg;
   logic                 irqPending;
   logic [CNT_W:0]       step;
   logic [CNT_W-1:0]     vLimit;
   pgw_sel_type          sel;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_next    = st_reg;
      step       = '0;
      vLimit     = '0;
      sel        = SEL_NONE;
      resetEvent = st_reg.swResetReq | supplyGlitch
                 | (externalResetPin & ~st_reg.prevPin);
      readFault  = regRead && (regAddr == ADDR_FAULT_SRC);
      clrTop     = (regWrite && regAddr == ADDR_TOP_FLAG) ? regWrData : 8'h00;
      clrReg     = (regWrite && regAddr == ADDR_REG_FLAG) ? regWrData : 8'h00;
      st_next.prevPin    = externalResetPin;
      st_next.swResetReq = regWrite && (regAddr == ADDR_CTRL) && regWrData[CTRL_SWRST_BIT];
      for (int i = 0; i < NUM_RAILS; i++) begin
         // Voltage window check, ramp forces invalid
         vRaw[i] = outAboveUv[i] & (st_reg.outCtrl[OC_WINDOW_BIT] ? outBelowOv[i] : 1'b1)
                 & ~rampActive[i];
         vLimit = st_reg.vFilt[i] ? LIM_INVALID :
                  (st_reg.outCtrl[OC_SETDLY_BIT] ? LIM_VLONG : LIM_VSHORT);
         step = deb_step(vRaw[i], st_reg.vFilt[i], st_reg.vCnt[i], vLimit);
         st_next.vFilt[i] = step[CNT_W];
         st_next.vCnt[i]  = step[CNT_W-1:0];
         step = deb_step(forwardCurrentLimit[i], st_reg.iFilt[i], st_reg.iCnt[i], LIM_ILIM);
         st_next.iFilt[i] = step[CNT_W];
         st_next.iCnt[i]  = step[CNT_W-1:0];
         step = deb_step(outputCollapsed[i] & regEnable[i], st_reg.oFilt[i], st_reg.oCnt[i],
                         st_reg.oFilt[i] ? LIM_ILIM : LIM_OVLD);
         st_next.oFilt[i] = step[CNT_W];
         st_next.oCnt[i]  = step[CNT_W-1:0];
         // Per-rail contribution
         sel = pgw_sel_type'(st_reg.srcCtrl[2*i +: 2]);
         disPending[i] = st_reg.scFlag[i] | thermalSdPending | supplyOvPending;
         if (sel == SEL_NONE) begin
            railIn[i] = 1'b1;
         end else if (disPending[i]) begin
            railIn[i] = 1'b0;
         end else if (!regEnable[i] || shutdownPhase[i]) begin
            railIn[i] = 1'b1;
         end else if (sel == SEL_VOLTAGE) begin
            railIn[i] = st_reg.vFilt[i] & ~rampActive[i];
         end else begin
            railIn[i] = st_reg.vFilt[i] & ~rampActive[i] & ~st_reg.iFilt[i];
         end
         // Fault record, set wins over read clear
         st_next.faultBits[i] = (st_reg.faultBits[i] & ~(readFault & railIn[i]))
                              | ~railIn[i];
         st_next.ilimFlag[i] = (st_reg.ilimFlag[i] & ~clrReg[i]) | st_reg.iFilt[i];
         st_next.scFlag[i]   = (st_reg.scFlag[i] & ~clrReg[SC_FLAG_LSB+i])
                             | (st_reg.oFilt[i] & regEnable[i]);
      end
      // Thermal warning
      step = deb_step(dieAboveWarn[st_reg.threshSel], st_reg.tFilt, st_reg.tCnt,
                      LIM_THERM);
      st_next.tFilt = step[CNT_W];
      st_next.tCnt  = step[CNT_W-1:0];
      st_next.thermFlag = (st_reg.thermFlag & ~clrTop[TOP_THERM_BIT]) | st_reg.tFilt;
      st_next.resetFlag = st_reg.resetFlag & ~clrTop[TOP_RESET_BIT];
      st_next.pgActive  = (&railIn)
                        & ~(st_reg.outCtrl[OC_STICKY_BIT] & (|st_reg.faultBits));
      // Configuration writes
      if (regWrite) begin
         case (regAddr)
            ADDR_CTRL: begin
               st_next.threshSel = regWrData[CTRL_THRESH_BIT];
            end
            ADDR_SRC_CTRL: begin
               st_next.srcCtrl = regWrData;
            end
            ADDR_OUT_CTRL: begin
               st_next.outCtrl = regWrData[4:0];
            end
            ADDR_MASK: begin
               st_next.mask = regWrData[NUM_RAILS+1:0];
            end
            default: begin
            end
         endcase
      end
      // Read data
      st_next.rdData = 8'h00;
      if (regRead) begin
         case (regAddr)
            ADDR_CTRL:      st_next.rdData = {6'h00, st_reg.threshSel, 1'b0};
            ADDR_SRC_CTRL:  st_next.rdData = st_reg.srcCtrl;
            ADDR_OUT_CTRL:  st_next.rdData = {3'h0, st_reg.outCtrl};
            ADDR_FAULT_SRC: st_next.rdData = {4'h0, st_reg.faultBits};
            ADDR_TOP_FLAG:  st_next.rdData = {6'h00, st_reg.thermFlag, st_reg.resetFlag};
            ADDR_REG_FLAG:  st_next.rdData = {st_reg.scFlag, st_reg.ilimFlag};
            ADDR_STATUS:    st_next.rdData = {2'h0, st_reg.pgActive, st_reg.tFilt,
                                              st_reg.iFilt};
            ADDR_ON_STATUS: st_next.rdData = {4'h0, regEnable & ~st_reg.scFlag};
            ADDR_MASK:      st_next.rdData = {2'h0, st_reg.mask};
            default:        st_next.rdData = 8'h00;
         endcase
      end
      // Reset events restore defaults
      if (resetEvent) begin
         st_next           = '0;
         st_next.resetFlag = 1'b1;
         st_next.prevPin   = externalResetPin;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg           <= '0;
         st_reg.resetFlag <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign irqPending = (st_reg.resetFlag & ~st_reg.mask[MASK_RESET_BIT])
                     | (st_reg.thermFlag & ~st_reg.mask[MASK_THERM_BIT])
                     | (|(st_reg.ilimFlag & ~st_reg.mask[MASK_ILIM_LSB +: NUM_RAILS]))
                     | (|st_reg.scFlag);
   assign irqLineNOut = 1'b0;
   assign irqLineNOe  = irqPending;
   assign powerGoodOut = st_reg.pgActive ^ st_reg.outCtrl[OC_POL_BIT];
   assign powerGoodOe  = ~st_reg.outCtrl[OC_OD_BIT] | ~powerGoodOut;
   assign regRdData         = st_reg.rdData;
   assign regulatorOnStatus = regEnable & ~st_reg.scFlag;
   assign regulatorShutdown = st_reg.scFlag;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_soft_reset;
      regWrite && regAddr == ADDR_CTRL && regWrData[CTRL_SWRST_BIT]
         |-> ##2 (st_reg.resetFlag && st_reg.srcCtrl == '0 && st_reg.outCtrl == '0);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

   property p_and_rails;
      st_reg.pgActive |-> $past(&railIn);
   endproperty
   a_and_rails: assert property (p_and_rails) else $error("pg active with bad rail");

   property p_sticky;
      st_reg.outCtrl[OC_STICKY_BIT] && (|st_reg.faultBits) |=> !st_reg.pgActive;
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky fault ignored");

   property p_fault_read;
      readFault && !resetEvent |=> st_reg.faultBits == ~$past(railIn);
   endproperty
   a_fault_read: assert property (p_fault_read) else $error("fault read clear wrong");

   property p_drive_type;
      (!st_reg.outCtrl[OC_OD_BIT] |-> powerGoodOe)
      and (st_reg.outCtrl[OC_OD_BIT] |-> powerGoodOe == !powerGoodOut);
   endproperty
   a_drive_type: assert property (p_drive_type) else $error("pg drive type wrong");

   property p_irq_reset_flag;
      st_reg.resetFlag && !st_reg.mask[MASK_RESET_BIT] |-> irqLineNOe && !irqLineNOut;
   endproperty
   a_irq_reset_flag: assert property (p_irq_reset_flag) else $error("irq not low");

   property p_ilim_flag;
      $rose(st_reg.iFilt[0]) && !resetEvent |=> st_reg.ilimFlag[0];
   endproperty
   a_ilim_flag: assert property (p_ilim_flag) else $error("ilim flag not set");

   property p_sc_status;
      st_reg.scFlag[0] |-> !regulatorOnStatus[0] && regulatorShutdown[0];
   endproperty
   a_sc_status: assert property (p_sc_status) else $error("sc status wrong");

   property p_invalid_filter;
      $fell(st_reg.vFilt[0]) && $past(!resetEvent) |-> $past(st_reg.vCnt[0]) == LIM_INVALID - 1;
   endproperty
   a_invalid_filter: assert property (p_invalid_filter) else $error("invalid filter time");

   property p_therm_flag;
      st_reg.tFilt && !resetEvent |=> st_reg.thermFlag;
   endproperty
   a_therm_flag: assert property (p_therm_flag) else $error("thermal flag not set");

   c_pg_active:  cover property ($rose(st_reg.pgActive));
   c_fault_read: cover property (readFault && |st_reg.faultBits);
   c_sc_event:   cover property ($rose(st_reg.scFlag[0]));
   c_therm:      cover property ($rose(st_reg.thermFlag));

endmodule : pgw_power_good
`default_nettype wire

// >>> testbench/pgw_host_model.sv
// Host side model of the pulled-up power-good and interrupt wires
`default_nettype none
module pgw_host_model (
   input  wire logic pgDrive,
   input  wire logic pgOe,
   input  wire logic irqDrive,
   input  wire logic irqOe,
   output var  logic pgPin,
   output var  logic irqPinN
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Wire levels with pull-ups
   // ----------------------------------------------------------------
   assign pgPin   = pgOe ? pgDrive : 1'b1;
   assign irqPinN = irqOe ? irqDrive : 1'b1;
endmodule : pgw_host_model
`default_nettype wire

// >>> testbench/pgw_power_good_tb_top.sv
// Self-checking bench of the power-good and warning flag block
`default_nettype none
module pgw_power_good_tb_top
   import pgw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEB = 8;
   localparam int OV  = 16;
   logic clk = 1'b0, rst_b = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rdVal;
   logic externalResetPin = 1'b0, supplyGlitch = 1'b0;
   logic thermalSdPending = 1'b0, supplyOvPending = 1'b0;
   logic [3:0] regEnable = 4'hf, outAboveUv = 4'he, outBelowOv = 4'hf, rampActive = 4'h0;
   logic [3:0] shutdownPhase = 4'h0, forwardCurrentLimit = 4'h0, outputCollapsed = 4'h0;
   logic [1:0] dieAboveWarn = 2'b00;
   logic powerGoodOut, powerGoodOe, irqLineNOut, irqLineNOe, pgPin, irqPinN;
   logic [3:0] regulatorOnStatus, regulatorShutdown;
   wire logic [7:0] pgByte  = {7'h0, powerGoodOut};
   wire logic [7:0] irqByte = {7'h0, irqPinN};
   wire logic [7:0] pinByte = {5'h0, powerGoodOut, powerGoodOe, pgPin};
   int n_errors = 0;
   int checks = 0;
   always #2 clk = ~clk;
   pgw_power_good #(.ILIM_CYC(DEB), .THERM_CYC(DEB), .OVLD_CYC(OV)) u_dut (
      .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .externalResetPin(externalResetPin), .supplyGlitch(supplyGlitch),
      .regEnable(regEnable), .outAboveUv(outAboveUv), .outBelowOv(outBelowOv),
      .rampActive(rampActive), .shutdownPhase(shutdownPhase),
      .forwardCurrentLimit(forwardCurrentLimit), .outputCollapsed(outputCollapsed),
      .thermalSdPending(thermalSdPending), .supplyOvPending(supplyOvPending),
      .dieAboveWarn(dieAboveWarn), .powerGoodOut(powerGoodOut), .powerGoodOe(powerGoodOe),
      .irqLineNOut(irqLineNOut), .irqLineNOe(irqLineNOe),
      .regulatorOnStatus(regulatorOnStatus), .regulatorShutdown(regulatorShutdown));
   pgw_host_model u_host (.pgDrive(powerGoodOut), .pgOe(powerGoodOe), .irqDrive(irqLineNOut),
      .irqOe(irqLineNOe), .pgPin(pgPin), .irqPinN(irqPinN));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      if (n_errors == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk) regWrite <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk) regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk) regRead <= 1'b0;
      #1 rdVal = regRdData;
   endtask : rd
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_defaults();
      rd(ADDR_TOP_FLAG);
      chk(rdVal, 8'h01);
      chk(irqByte, 8'h00);
      chk(pgByte, 8'h01);
      wr(8'h3f, 8'hff);
      rd(8'h3f);
      chk(rdVal, 8'h00);
      wr(ADDR_TOP_FLAG, 8'h01);
      wt(1);
      chk(irqByte, 8'h01);
   endtask : t_defaults
   task automatic t_voltage();
      wr(ADDR_SRC_CTRL, 8'h01);
      wt(4);
      chk(pgByte, 8'h00);
      @(posedge clk) outAboveUv[0] <= 1'b1;
      wt(VALID_SHORT_CYC - 10);
      chk(pgByte, 8'h00);
      wt(20);
      chk(pgByte, 8'h01);
      rd(ADDR_FAULT_SRC);
      chk(rdVal, 8'h01);
      rd(ADDR_FAULT_SRC);
      chk(rdVal, 8'h00);
      @(posedge clk) outAboveUv[0] <= 1'b0;
      wt(INVALID_CYC - 10);
      chk(pgByte, 8'h01);
      wt(20);
      chk(pgByte, 8'h00);
      rd(ADDR_FAULT_SRC);
      rd(ADDR_FAULT_SRC);
      chk(rdVal, 8'h01);
      @(posedge clk) outAboveUv[0] <= 1'b1;
      wt(VALID_SHORT_CYC + 10);
      rd(ADDR_FAULT_SRC);
   endtask : t_voltage
   task automatic t_window_ramp();
      @(posedge clk) outBelowOv[0] <= 1'b0;
      wt(INVALID_CYC + 10);
      chk(pgByte, 8'h01);
      wr(ADDR_OUT_CTRL, 8'h09);
      wt(INVALID_CYC + 10);
      chk(pgByte, 8'h00);
      @(posedge clk) outBelowOv[0] <= 1'b1;
      wt(VALID_LONG_CYC - 10);
      chk(pgByte, 8'h00);
      wt(20);
      chk(pgByte, 8'h01);
      @(posedge clk) rampActive[0] <= 1'b1;
      wt(3);
      chk(pgByte, 8'h00);
      @(posedge clk) rampActive[0] <= 1'b0;
      wt(VALID_LONG_CYC + 10);
      chk(pgByte, 8'h01);
      wr(ADDR_OUT_CTRL, 8'h00);
      rd(ADDR_FAULT_SRC);
   endtask : t_window_ramp
   task automatic t_masked();
      @(posedge clk) shutdownPhase[0] <= 1'b1;
      outAboveUv[0] <= 1'b0;
      wt(INVALID_CYC + 10);
      chk(pgByte, 8'h01);
      @(posedge clk) shutdownPhase[0] <= 1'b0;
      regEnable[0] <= 1'b0;
      wt(3);
      chk(pgByte, 8'h01);
      rd(ADDR_ON_STATUS);
      chk(rdVal, 8'h0e);
      @(posedge clk) regEnable[0] <= 1'b1;
      outAboveUv[0] <= 1'b1;
      wt(3);
      chk(pgByte, 8'h00);
      wt(VALID_SHORT_CYC + 10);
      rd(ADDR_FAULT_SRC);
   endtask : t_masked
   task automatic t_current();
      @(posedge clk) forwardCurrentLimit[0] <= 1'b1;
      wt(DEB + 4);
      chk(pgByte, 8'h01);
      rd(ADDR_REG_FLAG);
      chk(rdVal, 8'h01);
      rd(ADDR_STATUS);
      chk(rdVal, 8'h21);
      chk(irqByte, 8'h00);
      wr(ADDR_REG_FLAG, 8'h01);
      rd(ADDR_REG_FLAG);
      chk(rdVal, 8'h01);
      for (int s = 2; s < 4; s++) begin
         wr(ADDR_SRC_CTRL, s[7:0]);
         wt(3);
         chk(pgByte, 8'h00);
      end
      @(posedge clk) forwardCurrentLimit[0] <= 1'b0;
      wt(DEB + 4);
      chk(pgByte, 8'h01);
      wr(ADDR_REG_FLAG, 8'h01);
      wt(1);
      chk(irqByte, 8'h01);
      wr(ADDR_SRC_CTRL, 8'h01);
      rd(ADDR_FAULT_SRC);
   endtask : t_current
   task automatic t_thermal();
      @(posedge clk) dieAboveWarn <= 2'b10;
      wt(DEB + 4);
      rd(ADDR_TOP_FLAG);
      chk(rdVal, 8'h00);
      wr(ADDR_CTRL, 8'h02);
      wt(DEB + 4);
      rd(ADDR_TOP_FLAG);
      chk(rdVal, 8'h02);
      chk(irqByte, 8'h00);
      wr(ADDR_MASK, 8'h02);
      wt(1);
      chk(irqByte, 8'h01);
      rd(ADDR_STATUS);
      chk(rdVal, 8'h30);
      @(posedge clk) dieAboveWarn <= 2'b00;
      wt(DEB + 4);
      wr(ADDR_TOP_FLAG, 8'h02);
      rd(ADDR_TOP_FLAG);
      chk(rdVal, 8'h00);
      wr(ADDR_MASK, 8'h00);
   endtask : t_thermal
   task automatic t_sticky();
      wr(ADDR_OUT_CTRL, 8'h10);
      @(posedge clk) rampActive[0] <= 1'b1;
      wt(3);
      @(posedge clk) rampActive[0] <= 1'b0;
      wt(VALID_SHORT_CYC + 10);
      chk(pgByte, 8'h00);
      rd(ADDR_FAULT_SRC);
      chk(rdVal, 8'h01);
      wt(3);
      chk(pgByte, 8'h01);
      wr(ADDR_OUT_CTRL, 8'h00);
   endtask : t_sticky
   task automatic t_short();
      @(posedge clk) outputCollapsed[0] <= 1'b1;
      wt(OV + 4);
      chk({4'h0, regulatorOnStatus}, 8'h0e);
      chk({4'h0, regulatorShutdown}, 8'h01);
      chk(pgByte, 8'h00);
      chk(irqByte, 8'h00);
      rd(ADDR_REG_FLAG);
      chk(rdVal, 8'h10);
      @(posedge clk) outputCollapsed[0] <= 1'b0;
      wt(DEB + 4);
      wr(ADDR_REG_FLAG, 8'h10);
      rd(ADDR_REG_FLAG);
      chk(rdVal, 8'h00);
      for (int i = 1; i < 3; i++) begin
         @(posedge clk) {supplyOvPending, thermalSdPending} <= i[1:0];
         wt(3);
         chk(pgByte, 8'h00);
      end
      @(posedge clk) {supplyOvPending, thermalSdPending} <= 2'b00;
      wt(3);
      chk(pgByte, 8'h01);
      rd(ADDR_FAULT_SRC);
   endtask : t_short
   task automatic t_polarity();
      wr(ADDR_OUT_CTRL, 8'h02);
      wt(2);
      chk(pinByte, 8'h02);
      wr(ADDR_OUT_CTRL, 8'h06);
      @(posedge clk) thermalSdPending <= 1'b1;
      wt(3);
      chk(pinByte, 8'h05);
      wr(ADDR_OUT_CTRL, 8'h04);
      wt(2);
      chk(pinByte, 8'h02);
      @(posedge clk) thermalSdPending <= 1'b0;
      wt(3);
      chk(pinByte, 8'h05);
   endtask : t_polarity
   task automatic t_reset_events();
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_OUT_CTRL, 8'h08);
         @(posedge clk) externalResetPin <= (i == 1);
         supplyGlitch <= (i == 2);
         regWrite <= (i == 0);
         regAddr <= ADDR_CTRL;
         regWrData <= 8'h01;
         @(posedge clk) supplyGlitch <= 1'b0;
         regWrite <= 1'b0;
         wt(3);
         rd(ADDR_TOP_FLAG);
         chk(rdVal, 8'h01);
         rd(ADDR_OUT_CTRL);
         chk(rdVal, 8'h00);
         rd(ADDR_CTRL);
         chk(rdVal, 8'h00);
         wr(ADDR_TOP_FLAG, 8'h01);
      end
   endtask : t_reset_events
   // ----------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      wt(2);
      t_defaults();
      t_voltage();
      t_window_ramp();
      t_masked();
      t_current();
      t_thermal();
      t_sticky();
      t_short();
      t_polarity();
      t_reset_events();
      report_and_stop();
   end
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule : pgw_power_good_tb_top
`default_nettype wire
